//--- core/bmc_core.sv
// Purpose: mode, enable, reference ramp and fault control of a step-down converter
// Assumes: all inputs synchronous to i_clock; comparators deliver clean levels
// Notes:   registers reached over a two-wire serial slave on i_scl / SDA
`default_nettype none
module bmc_core
   import bmc_pkg::*;
#(
   parameter int unsigned P_HICCUP_CYC = HICCUP_CYC,
   parameter int unsigned P_RETRY_CYC  = RETRY_CYC
) (
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_nrst,
   // Serial register port
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda_out,
   output logic            o_sda_oe,
   // Control pins
   input  wire logic       i_enable_pin,
   input  wire logic       i_preset_select_pin,
   // Comparator levels
   input  wire logic       i_supply_above_rise,
   input  wire logic       i_supply_below_fall,
   input  wire logic       i_temp_above_rise,
   input  wire logic       i_temp_below_fall,
   input  wire logic       i_power_good_above,
   input  wire logic       i_out_below_half,
   input  wire logic       i_out_below_target,
   input  wire logic       i_softstart_done,
   input  wire logic       i_duty_end,
   input  wire logic       i_min_peak,
   input  wire logic       i_zero_current,
   input  wire logic       i_overcurrent,
   // Power stage and loop controls
   output logic            o_high_side_on,
   output logic            o_low_side_on,
   output logic            o_discharge_on,
   output logic            o_soft_start,
   output logic            o_regulating,
   output logic [6:0]      o_ref_code,
   output logic [1:0]      o_ref_bank,
   output logic [1:0]      o_current_limit_field
);

   bmc_i2c_t    i2c_state;
   bmc_conv_t   conv_state;
   bmc_sw_t     sw_state;
   logic        scl_q;
   logic        sda_q;
   logic        i2c_start;
   logic        i2c_stop;
   logic        scl_rise;
   logic        scl_fall;
   logic [3:0]  bit_cnt;
   logic [7:0]  shreg;
   logic [7:0]  ptr;
   logic        rw_bit;
   logic        host_nack;
   logic        sda_drive;
   logic        wr_stb;
   logic [7:0]  rd_data;
   logic [7:0]  preset_one;
   logic [7:0]  preset_zero;
   logic [7:0]  discharge_ctl;
   logic [7:0]  forced_sel;
   logic [1:0]  cur_limit;
   logic [1:0]  bank_one;
   logic [1:0]  bank_zero;
   logic [2:0]  fault_rec;
   logic        power_good_flag;
   logic        supply_ok;
   logic        temp_latched;
   logic        sel_enable;
   logic [6:0]  sel_code;
   logic        sel_forced;
   logic [1:0]  sel_bank;
   logic        run_req;
   logic        active;
   logic [16:0] timer;
   logic [4:0]  sw_acc;
   logic        sw_tick;
   logic [7:0]  ramp_cnt;

   // Bus edge and condition detection
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda;
      end
   end
   assign scl_rise  = i_scl & ~scl_q;
   assign scl_fall  = ~i_scl & scl_q;
   assign i2c_start = i_scl & scl_q & sda_q & ~i_sda;
   assign i2c_stop  = i_scl & scl_q & ~sda_q & i_sda;
   assign wr_stb    = scl_fall && (bit_cnt == 4'h7) && (i2c_state == IS_WR);

   // Read data mux; unmapped offsets read zero
   always_comb begin
      case (ptr)
         REG_POWER_GOOD:  rd_data = {7'h00, power_good_flag};
         REG_PRESET_ONE:  rd_data = preset_one;
         REG_PRESET_ZERO: rd_data = preset_zero;
         REG_DISCHARGE:   rd_data = discharge_ctl;
         REG_FORCED_MODE: rd_data = forced_sel;
         REG_CUR_LIMIT:   rd_data = {6'h00, cur_limit};
         REG_FAULT_REC:   rd_data = {5'h00, fault_rec};
         REG_BANK_ONE:    rd_data = {6'h00, bank_one};
         REG_BANK_ZERO:   rd_data = {6'h00, bank_zero};
         default:         rd_data = 8'h00;
      endcase
   end

   // Serial slave: address, register pointer, auto-increment data bytes
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         i2c_state <= IS_IDLE;
         bit_cnt   <= 4'h0;
         shreg     <= 8'h00;
         ptr       <= 8'h00;
         rw_bit    <= 1'b0;
         host_nack <= 1'b0;
         sda_drive <= 1'b0;
      end else if (i2c_start) begin
         i2c_state <= IS_ADDR;
         bit_cnt   <= 4'hf;  // Wraps on first fall
         sda_drive <= 1'b0;
      end else if (i2c_stop) begin
         i2c_state <= IS_IDLE;
         sda_drive <= 1'b0;
      end else if (scl_rise && i2c_state != IS_IDLE) begin
         if (bit_cnt == 4'h8) begin
            host_nack <= i_sda;
         end else if (i2c_state != IS_RD) begin
            shreg <= {shreg[6:0], i_sda};
         end
      end else if (scl_fall && i2c_state != IS_IDLE) begin
         if (bit_cnt == 4'h7) begin
            // Byte complete: acknowledge or release for host acknowledge
            bit_cnt   <= 4'h8;
            sda_drive <= 1'b0;
            case (i2c_state)
               IS_ADDR: begin
                  if (shreg[7:1] == DEV_ADDR) begin
                     sda_drive <= 1'b1;
                     rw_bit    <= shreg[0];
                  end else begin
                     i2c_state <= IS_IDLE;
                  end
               end
               IS_REG: begin
                  ptr       <= shreg;
                  sda_drive <= 1'b1;
               end
               IS_WR: begin
                  ptr       <= ptr + 8'h01;
                  sda_drive <= 1'b1;
               end
               default: sda_drive <= 1'b0;
            endcase
         end else if (bit_cnt == 4'h8) begin
            bit_cnt   <= 4'h0;
            sda_drive <= 1'b0;
            case (i2c_state)
               IS_ADDR: begin
                  if (rw_bit) begin
                     i2c_state <= IS_RD;
                     shreg     <= rd_data;
                     sda_drive <= ~rd_data[7];
                     ptr       <= ptr + 8'h01;
                  end else begin
                     i2c_state <= IS_REG;
                  end
               end
               IS_REG:  i2c_state <= IS_WR;
               IS_WR:   i2c_state <= IS_WR;
               IS_RD: begin
                  if (host_nack) begin
                     i2c_state <= IS_IDLE;
                  end else begin
                     shreg     <= rd_data;
                     sda_drive <= ~rd_data[7];
                     ptr       <= ptr + 8'h01;
                  end
               end
               default: i2c_state <= IS_IDLE;
            endcase
         end else begin
            bit_cnt <= bit_cnt + 4'h1;
            if (i2c_state == IS_RD) begin
               shreg     <= {shreg[6:0], 1'b0};
               sda_drive <= ~shreg[6];
            end else begin
               sda_drive <= 1'b0;
            end
         end
      end
   end
   assign o_sda_out = 1'b0;  // Open drain: only ever pulls low
   assign o_sda_oe  = sda_drive;

   // Writable registers; retained while the converter is off
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         preset_one    <= PRESET_ONE_RST;
         preset_zero   <= PRESET_ZERO_RST;
         discharge_ctl <= DISCH_RST;
         forced_sel    <= FORCED_RST;
         cur_limit     <= CUR_LIMIT_RST;
         bank_one      <= BANK_ONE_RST;
         bank_zero     <= BANK_ZERO_RST;
      end else if (wr_stb) begin
         case (ptr)
            REG_PRESET_ONE:  preset_one    <= shreg;
            REG_PRESET_ZERO: preset_zero   <= shreg;
            REG_DISCHARGE:   discharge_ctl <= shreg;
            REG_FORCED_MODE: forced_sel    <= shreg;
            REG_CUR_LIMIT:   cur_limit     <= shreg[1:0];
            REG_BANK_ONE:    bank_one      <= shreg[1:0];
            REG_BANK_ZERO:   bank_zero     <= shreg[1:0];
            default:         cur_limit     <= cur_limit;
         endcase
      end
   end
   assign o_current_limit_field = cur_limit;

   // Sticky fault records: write one to clear, a new event wins over the clear
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         fault_rec <= 3'h0;
      end else begin
         if (wr_stb && ptr == REG_FAULT_REC) begin
            fault_rec <= fault_rec & ~shreg[2:0];
         end
         if (supply_ok && i_supply_below_fall) begin
            fault_rec[FLT_LOCK_BIT] <= 1'b1;
         end
         if ((conv_state == CV_RUN && i_out_below_half) ||
             (conv_state == CV_SOFT && timer >= 17'(P_RETRY_CYC - 1))) begin
            fault_rec[FLT_SHORT_BIT] <= 1'b1;
         end
         if (active && i_overcurrent) begin
            fault_rec[FLT_OVERC_BIT] <= 1'b1;
         end
      end
   end

   // Status sampling: power good, supply lockout, thermal latch
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         power_good_flag <= 1'b0;
         supply_ok       <= 1'b0;
         temp_latched    <= 1'b0;
      end else begin
         power_good_flag <= i_power_good_above;
         if (i_supply_above_rise) begin
            supply_ok <= 1'b1;
         end else if (i_supply_below_fall) begin
            supply_ok <= 1'b0;
         end
         // Set has priority so a hot die never slips through
         if (i_temp_above_rise) begin
            temp_latched <= 1'b1;
         end else if (i_temp_below_fall) begin
            temp_latched <= 1'b0;
         end
      end
   end

   // Preset set chosen as one group by the select pin
   assign sel_enable = i_preset_select_pin ? preset_one[PRESET_EN_BIT]
                                           : preset_zero[PRESET_EN_BIT];
   assign sel_code   = i_preset_select_pin ? preset_one[6:0] : preset_zero[6:0];
   assign sel_forced = i_preset_select_pin ? forced_sel[FORCED1_BIT]
                                           : forced_sel[FORCED0_BIT];
   assign sel_bank   = i_preset_select_pin ? bank_one : bank_zero;
   // Any loss of a run condition drops to off, which also ends a hiccup wait; the short record stays set
   assign run_req = i_enable_pin & sel_enable & supply_ok & ~temp_latched;

   // Converter sequence with soft-start window and hiccup wait
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         conv_state <= CV_OFF;
         timer      <= 17'h00000;
      end else if (!run_req) begin
         conv_state <= CV_OFF;
         timer      <= 17'h00000;
      end else begin
         timer <= timer + 17'h00001;
         case (conv_state)
            CV_OFF: begin
               conv_state <= CV_SOFT;
               timer      <= 17'h00000;
            end
            CV_SOFT: begin
               if (i_softstart_done) begin
                  conv_state <= CV_RUN;
                  timer      <= 17'h00000;
               end else if (timer >= 17'(P_RETRY_CYC - 1)) begin
                  conv_state <= CV_HICCUP;
                  timer      <= 17'h00000;
               end
            end
            CV_RUN: begin
               timer <= 17'h00000;
               if (i_out_below_half) begin
                  conv_state <= CV_HICCUP;
               end
            end
            CV_HICCUP: begin
               // Held off; only a restart attempt after the wait
               if (timer >= 17'(P_HICCUP_CYC - 1)) begin
                  conv_state <= CV_SOFT;
                  timer      <= 17'h00000;
               end
            end
            default: begin
               conv_state <= CV_OFF;
               timer      <= 17'h00000;
            end
         endcase
      end
   end
   assign active         = (conv_state == CV_SOFT) || (conv_state == CV_RUN);
   assign o_regulating   = active;
   assign o_soft_start   = (conv_state == CV_SOFT);
   assign o_discharge_on = (conv_state != CV_SOFT) && (conv_state != CV_RUN) &&
                           discharge_ctl[DISCH_BIT];

   // Fractional divider: exact 3 MHz average tick from 20 MHz
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         sw_acc  <= 5'h00;
         sw_tick <= 1'b0;
      end else if (sw_acc + SW_ACC_STEP >= SW_ACC_WRAP) begin
         sw_acc  <= sw_acc + SW_ACC_STEP - SW_ACC_WRAP;
         sw_tick <= 1'b1;
      end else begin
         sw_acc  <= sw_acc + SW_ACC_STEP;
         sw_tick <= 1'b0;
      end
   end

   // Switching cycle: width, skip and minimum-peak wake
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         sw_state <= SW_OFF;
      end else if (!active) begin
         sw_state <= SW_OFF;
      end else begin
         case (sw_state)
            SW_OFF: begin
               if (sw_tick && !i_overcurrent) begin
                  sw_state <= SW_HS;
               end
            end
            SW_HS: begin
               if (i_overcurrent || i_duty_end) begin
                  sw_state <= SW_LS;
               end
            end
            SW_LS: begin
               if (!sel_forced && i_zero_current) begin
                  sw_state <= SW_SKIP;
               end else if (sw_tick && !i_overcurrent) begin
                  sw_state <= SW_HS;
               end
            end
            SW_SKIP: begin
               // Forced mode chosen mid-skip resumes fixed-rate switching
               if (sw_tick && !i_overcurrent && sel_forced) begin
                  sw_state <= SW_HS;
               end else if (sw_tick && !i_overcurrent && i_out_below_target) begin
                  sw_state <= SW_MINPK;
               end
            end
            SW_MINPK: begin
               if (i_min_peak || i_overcurrent) begin
                  sw_state <= SW_LS;
               end
            end
            default: sw_state <= SW_OFF;
         endcase
      end
   end
   assign o_high_side_on = (sw_state == SW_HS) || (sw_state == SW_MINPK);
   assign o_low_side_on  = (sw_state == SW_LS);

   // Reference ramp; bank change or idle converter loads the target directly
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ref_code <= PRESET_ZERO_RST[6:0];
         o_ref_bank <= BANK_ZERO_RST;
         ramp_cnt   <= 8'h00;
      end else if (!active || sel_bank != o_ref_bank) begin
         o_ref_code <= sel_code;
         o_ref_bank <= sel_bank;
         ramp_cnt   <= 8'h00;
      end else if (o_ref_code == sel_code) begin
         ramp_cnt <= 8'h00;
      end else if (ramp_cnt >= RAMP_CYC - 8'h01) begin
         ramp_cnt <= 8'h00;
         // One code per step interval approximates the slew rate
         if (o_ref_code < sel_code) begin
            o_ref_code <= o_ref_code + 7'h01;
         end else begin
            o_ref_code <= o_ref_code - 7'h01;
         end
      end else begin
         ramp_cnt <= ramp_cnt + 8'h01;
      end
   end

endmodule : bmc_core
`default_nettype wire

//--- core/bmc_pkg.sv
// Purpose: shared constants and types for the buck mode/enable/fault controller
// Assumes: 20 MHz system clock, 3 MHz switching rate made by a fractional divider
// Notes:   register offsets, field positions, reset values and timing counts
`default_nettype none
package bmc_pkg;
   // Clock and switching rate
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned SW_HZ       = 3_000_000;
   localparam logic [4:0]  SW_ACC_STEP = 5'(SW_HZ / 1_000_000);
   localparam logic [4:0]  SW_ACC_WRAP = 5'(CLK_HZ / 1_000_000);
   // Protection and ramp times, figures as printed
   localparam int unsigned HICCUP_MS    = 4;
   localparam int unsigned RETRY_MS     = 1;
   localparam int unsigned RAMP_STEP_US = 10;
   localparam int unsigned RAMP_STEP_MV = 3;
   localparam int unsigned HICCUP_CYC   = CLK_HZ / 1000 * HICCUP_MS;
   localparam int unsigned RETRY_CYC    = CLK_HZ / 1000 * RETRY_MS;
   localparam logic [7:0]  RAMP_CYC     = 8'(CLK_HZ / 1_000_000 * RAMP_STEP_US);
   // Two-wire slave address, arbitrary
   localparam logic [6:0]  DEV_ADDR     = 7'h3a;
   // Register offsets
   localparam logic [7:0] REG_POWER_GOOD  = 8'h01;
   localparam logic [7:0] REG_PRESET_ONE  = 8'h10;
   localparam logic [7:0] REG_PRESET_ZERO = 8'h11;
   localparam logic [7:0] REG_DISCHARGE   = 8'h12;
   localparam logic [7:0] REG_FORCED_MODE = 8'h14;
   localparam logic [7:0] REG_CUR_LIMIT   = 8'h16;
   localparam logic [7:0] REG_FAULT_REC   = 8'h18;
   localparam logic [7:0] REG_BANK_ONE    = 8'h1c;
   localparam logic [7:0] REG_BANK_ZERO   = 8'h1d;
   // Field positions
   localparam int unsigned PRESET_EN_BIT = 7;
   localparam int unsigned FORCED0_BIT   = 0;
   localparam int unsigned FORCED1_BIT   = 1;
   localparam int unsigned DISCH_BIT     = 0;
   localparam int unsigned FLT_LOCK_BIT  = 0;
   localparam int unsigned FLT_SHORT_BIT = 1;
   localparam int unsigned FLT_OVERC_BIT = 2;
   // Reset values
   localparam logic [7:0] PRESET_ONE_RST  = 8'ha8;
   localparam logic [7:0] PRESET_ZERO_RST = 8'ha4;
   localparam logic [7:0] DISCH_RST       = 8'h01;
   localparam logic [7:0] FORCED_RST      = 8'h00;
   localparam logic [1:0] CUR_LIMIT_RST   = 2'h3;
   localparam logic [1:0] BANK_ONE_RST    = 2'h1;
   localparam logic [1:0] BANK_ZERO_RST   = 2'h1;
   // State encodings, one-hot
   typedef enum logic [4:0] {
      IS_IDLE = 5'h01, IS_ADDR = 5'h02, IS_REG = 5'h04, IS_WR = 5'h08, IS_RD = 5'h10
   } bmc_i2c_t;
   typedef enum logic [3:0] {
      CV_OFF = 4'h1, CV_SOFT = 4'h2, CV_RUN = 4'h4, CV_HICCUP = 4'h8
   } bmc_conv_t;
   typedef enum logic [4:0] {
      SW_OFF = 5'h01, SW_HS = 5'h02, SW_LS = 5'h04, SW_SKIP = 5'h08, SW_MINPK = 5'h10
   } bmc_sw_t;
endpackage : bmc_pkg
`default_nettype wire

//--- dv/bmc_core_monitor.sv
// Purpose: port checker, converter controller
// Assumes: one clock; i_nrst async, active low
// Notes:   bound into every bmc_core
`default_nettype none
module bmc_core_monitor (
   // Clock and reset
   input wire logic       i_clock,
   input wire logic       i_nrst,
   // Pins and comparators
   input wire logic       i_enable_pin,
   input wire logic       i_supply_below_fall,
   input wire logic       i_temp_above_rise,
   input wire logic       i_out_below_half,
   input wire logic       i_overcurrent,
   // Stage and reference
   input wire logic       o_high_side_on,
   input wire logic       o_low_side_on,
   input wire logic       o_discharge_on,
   input wire logic       o_soft_start,
   input wire logic       o_regulating,
   input wire logic [6:0] o_ref_code,
   input wire logic [1:0] o_ref_bank
);
   default clocking mon_cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // Collapse after soft-start, then retry pause
   sequence s_collapse;
      o_regulating && !o_soft_start && i_out_below_half && i_enable_pin;
   endsequence
   sequence s_held_off;
      !o_regulating [*8];
   endsequence
   chk_pin_gate: assert property (!i_enable_pin |=> !o_regulating)
      else $error("running with enable pin low");
   chk_supply_drop: assert property (i_supply_below_fall |-> ##[1:2] !o_regulating)
      else $error("running in lockout");
   chk_heat_off: assert property (i_temp_above_rise |-> ##[1:2] !o_regulating)
      else $error("running while hot");
   chk_disch_excl: assert property (o_regulating |-> !o_discharge_on)
      else $error("discharge while regulating");
   chk_side_excl: assert property (!(o_high_side_on && o_low_side_on))
      else $error("both switches on");
   chk_oc_block: assert property ($rose(o_high_side_on) && $past(o_low_side_on)
      |-> !$past(i_overcurrent))
      else $error("pulse in over-current");
   chk_fault_hold: assert property (s_collapse |=> s_held_off)
      else $error("no pause after collapse");
   chk_ramp_step: assert property ($changed(o_ref_code) && $stable(o_ref_bank) && o_regulating
      && $past(o_regulating)
      |-> 7'(o_ref_code - $past(o_ref_code)) inside {7'h01, 7'h7f})
      else $error("reference jumped");
endmodule : bmc_core_monitor
bind bmc_core bmc_core_monitor
   u_mon (.i_clock(i_clock), .i_nrst(i_nrst), .i_enable_pin(i_enable_pin),
   .i_supply_below_fall(i_supply_below_fall), .i_temp_above_rise(i_temp_above_rise),
   .i_out_below_half(i_out_below_half), .i_overcurrent(i_overcurrent),
   .o_high_side_on(o_high_side_on), .o_low_side_on(o_low_side_on),
   .o_discharge_on(o_discharge_on), .o_soft_start(o_soft_start),
   .o_regulating(o_regulating), .o_ref_code(o_ref_code), .o_ref_bank(o_ref_bank));
`default_nettype wire

//--- dv/bmc_stage_model.sv
// Purpose: behavioural power stage and inductor for the controller
// Assumes: fixed clocks per conduction phase
// Notes:   light load lets low-side current reach zero
`default_nettype none
module bmc_stage_model (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // Gate drives and load
   input wire logic i_high_side_on,
   input wire logic i_low_side_on,
   input wire logic i_light_load,
   // Current flags
   output logic     o_duty_end,
   output logic     o_min_peak,
   output logic     o_zero_current
);
   logic [2:0] hs_cnt, ls_cnt;
   // Saturating phase counters
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         hs_cnt <= 3'h0;
         ls_cnt <= 3'h0;
      end else begin
         hs_cnt <= i_high_side_on ? hs_cnt + 3'(hs_cnt != 3'h7) : 3'h0;
         ls_cnt <= i_low_side_on ? ls_cnt + 3'(ls_cnt != 3'h7) : 3'h0;
      end
   end
   // Short phases fit a pulse between ticks
   assign o_min_peak     = hs_cnt >= 3'h1;
   assign o_duty_end     = hs_cnt >= 3'h2;
   assign o_zero_current = i_light_load && ls_cnt >= 3'h3;
endmodule : bmc_stage_model
`default_nettype wire

//--- dv/test_buck_mode_enable_fault_control.sv
// Purpose: bench for the converter controller
// Assumes: bench plays host and comparators
// Notes:   short hiccup and retry counts
`default_nettype none
module test_buck_mode_enable_fault_control;
   import bmc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HIC = 40;
   localparam int RET = 10;
   logic clk, nrst, scl, sda_d, en, sel, sr, sf, tr, tf, pg, half, bt, done, oc, lt;
   logic sdo, soe, hs, ls, dis, ss, run, de, mp, zc;
   logic [6:0] code;
   logic [1:0] bank, lim;
   logic [7:0] q;
   logic [7:0] offs [6] = '{REG_PRESET_ONE, REG_PRESET_ZERO, REG_DISCHARGE,
      REG_FORCED_MODE, REG_POWER_GOOD, 8'h30};
   logic [7:0] dflt [6] = '{PRESET_ONE_RST, PRESET_ZERO_RST, DISCH_RST, FORCED_RST, 8'h01, 8'h00};
   int n_mismatch, check_count, cnt;
   wire logic sda = sda_d & ~soe; // Pull-up, open drain
   bmc_core #(.P_HICCUP_CYC(HIC), .P_RETRY_CYC(RET)) uut (.i_clock(clk), .i_nrst(nrst),
      .i_scl(scl), .i_sda(sda), .o_sda_out(sdo), .o_sda_oe(soe), .i_enable_pin(en),
      .i_preset_select_pin(sel), .i_supply_above_rise(sr), .i_supply_below_fall(sf),
      .i_temp_above_rise(tr), .i_temp_below_fall(tf), .i_power_good_above(pg),
      .i_out_below_half(half), .i_out_below_target(bt), .i_softstart_done(done),
      .i_duty_end(de), .i_min_peak(mp), .i_zero_current(zc), .i_overcurrent(oc),
      .o_high_side_on(hs), .o_low_side_on(ls), .o_discharge_on(dis), .o_soft_start(ss),
      .o_regulating(run), .o_ref_code(code), .o_ref_bank(bank), .o_current_limit_field(lim));
   bmc_stage_model stage (.i_clock(clk), .i_nrst(nrst), .i_high_side_on(hs),
      .i_low_side_on(ls), .i_light_load(lt), .o_duty_end(de), .o_min_peak(mp),
      .o_zero_current(zc));
   // Free-running system clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic end_sim;
      if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // Switching ticks expected in n clocks
   function automatic int ticks(input int n);
      return n * int'(SW_ACC_STEP) / int'(SW_ACC_WRAP);
   endfunction : ticks
   // Bounded wait: run (w=0) or code (w=1)
   task automatic wait_on(input logic w, input logic [7:0] e, input int n);
      logic [7:0] cur;
      do begin
         cyc(1);
         cur = w ? 8'(code) : 8'(run);
         n--;
      end while (cur !== e && n > 0);
      chk(cur, e, "wait ran out");
      if (cur !== e) end_sim();
   endtask : wait_on
   // Each serial phase lasts three clocks
   task automatic pin(input logic c, input logic d);
      scl = c;
      sda_d = d;
      cyc(3);
   endtask : pin
   task automatic octet(input logic [7:0] d, input logic ack);
      logic [8:0] w;
      w = {d, 1'b1};
      for (int i = 8; i >= 0; i--) begin
         pin(1'b0, w[i]);
         pin(1'b1, w[i]);
         if (i > 0) q = {q[6:0], sda};
      end
      if (ack) chk(8'(sda), 8'h00, "no ack");
   endtask : octet
   task automatic start;
      pin(1'b0, 1'b1);
      pin(1'b1, 1'b1);
      pin(1'b1, 1'b0);
   endtask : start
   // Write (rw=0) or one-byte read into q (rw=1)
   task automatic xfer(input logic rw, input logic [7:0] a, input logic [7:0] d);
      start();
      octet({DEV_ADDR, 1'b0}, 1'b1);
      octet(a, 1'b1);
      if (rw) start();
      octet(rw ? {DEV_ADDR, 1'b1} : d, 1'b1);
      if (rw) octet(8'hff, 1'b0);
      pin(1'b0, 1'b0);
      pin(1'b1, 1'b0);
      pin(1'b1, 1'b1);
   endtask : xfer
   task automatic count_hs;
      logic p;
      cnt = 0;
      p = hs;
      repeat (200) begin
         cyc(1);
         cnt += int'(hs & ~p);
         p = hs;
      end
   endtask : count_hs
   // Main sequence
   initial begin
      {nrst, scl, sda_d, en, sel, sr, sf, tr, tf, pg, half, bt, done, oc, lt} = 15'h3020;
      void'($urandom(32'h608187d1));
      cyc(4);
      nrst = 1'b1;
      cyc(2);
      chk({dis, code}, {1'b1, PRESET_ZERO_RST[6:0]}, "reset outputs");
      chk({4'h0, bank, lim}, {4'h0, BANK_ZERO_RST, CUR_LIMIT_RST}, "reset fields");
      foreach (offs[i]) begin
         xfer(1'b1, offs[i], 8'h00);
         chk(q, dflt[i], "default");
      end
      {sel, sr, en, pg} = 4'hf;
      wait_on(1'b0, 8'h01, 10);
      chk(8'(code), 8'(PRESET_ONE_RST[6:0]), "preset one code");
      {done, lt} = 2'h3;
      xfer(1'b0, REG_FORCED_MODE, 8'h02);
      count_hs();
      chk(8'(cnt >= ticks(200) - 1), 8'h01, "forced rate");
      xfer(1'b0, REG_FORCED_MODE, 8'h01);
      count_hs();
      chk(8'(cnt < 3), 8'h01, "skip sleep");
      bt = 1'b1;
      count_hs();
      chk(8'(cnt >= ticks(200) / 2), 8'h01, "skip wake");
      {bt, lt} = 2'h0;
      sel = 1'b0;
      cyc(300);
      chk(8'(code == PRESET_ZERO_RST[6:0]), 8'h00, "ramp too fast");
      wait_on(1'b1, {1'b0, PRESET_ZERO_RST[6:0]}, 4 * int'(RAMP_CYC) + 10);
      repeat (2) begin
         cnt = 32 + $urandom_range(15);
         xfer(1'b0, REG_PRESET_ZERO, 8'(cnt) | 8'h80);
         wait_on(1'b1, 8'(cnt), 16 * int'(RAMP_CYC));
      end
      xfer(1'b0, REG_BANK_ZERO, 8'h02);
      chk(8'(bank), 8'h02, "bank jump");
      half = 1'b1;
      wait_on(1'b0, 8'h00, 3);
      half = 1'b0;
      wait_on(1'b0, 8'h01, HIC + 5);
      xfer(1'b1, REG_FAULT_REC, 8'h00);
      chk(q & 8'h02, 8'h02, "short record");
      xfer(1'b0, REG_FAULT_REC, 8'h02);
      xfer(1'b1, REG_FAULT_REC, 8'h00);
      chk(q & 8'h02, 8'h00, "short record clear");
      {done, half} = 2'h1;
      wait_on(1'b0, 8'h00, 3);
      half = 1'b0;
      wait_on(1'b0, 8'h01, HIC + 5);
      chk({6'h00, ss, sdo}, 8'h02, "soft-start flag");
      wait_on(1'b0, 8'h00, RET + 5);
      done = 1'b1;
      wait_on(1'b0, 8'h01, HIC + 5);
      oc = 1'b1;
      cyc(100);
      chk(8'(hs), 8'h00, "pulse in over-current");
      oc = 1'b0;
      xfer(1'b1, REG_FAULT_REC, 8'h00);
      chk(q & 8'h04, 8'h04, "over-current record");
      cnt = $urandom_range(3);
      xfer(1'b0, REG_CUR_LIMIT, 8'(cnt));
      chk(8'(lim), 8'(cnt), "limit field");
      tr = 1'b1;
      wait_on(1'b0, 8'h00, 4);
      tr = 1'b0;
      cyc(50);
      chk(8'(run), 8'h00, "thermal latch");
      tf = 1'b1;
      wait_on(1'b0, 8'h01, 10);
      tf = 1'b0;
      xfer(1'b0, REG_DISCHARGE, 8'h00);
      xfer(1'b0, REG_PRESET_ZERO, 8'h24);
      wait_on(1'b0, 8'h00, 3);
      chk(8'(dis), 8'h00, "discharge disabled");
      xfer(1'b0, REG_DISCHARGE, DISCH_RST);
      chk(8'(dis), 8'h01, "discharge at shutdown");
      xfer(1'b0, REG_PRESET_ZERO, 8'ha4);
      wait_on(1'b0, 8'h01, 10);
      {sr, sf} = 2'h1;
      wait_on(1'b0, 8'h00, 4);
      xfer(1'b1, REG_FAULT_REC, 8'h00);
      chk(q & 8'h01, 8'h01, "lockout record");
      en = 1'b0;
      cyc(3);
      end_sim();
   end
endmodule : test_buck_mode_enable_fault_control
`default_nettype wire
